// ===== hw/tsop_pkg.sv
package tsop_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_MONITOR  = 8'h04;
  localparam logic [7:0] ADDR_DIVIDER  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;
  localparam logic [7:0] ADDR_LIVE     = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Control and monitor register fields
  localparam int CTRL_TRISTATE = 0;
  localparam int CTRL_ERR_INV  = 1;
  localparam int CTRL_IRQ_CLK  = 2;
  localparam int CTRL_SEL_LO   = 4;
  localparam int CTRL_SEL_HI   = 5;
  localparam int MON_ERR_SRC   = 7;

  // Status pin function codes
  localparam logic [1:0] SEL_LOCK  = 2'h0;
  localparam logic [1:0] SEL_TONE  = 2'h1;
  localparam logic [1:0] SEL_ERROR = 2'h2;
  localparam logic [1:0] SEL_START = 2'h3;

  // Interrupt status bits
  localparam int IRQ_PKT = 0;
  localparam int IRQ_BLK = 1;
  localparam int IRQ_LOS = 2;
  localparam int IRQ_W   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]       CTRL_RST    = 8'h00;
  localparam logic [7:0]       MONITOR_RST = 8'h00;
  localparam logic [7:0]       DIVIDER_RST = 8'h01;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST  = 3'h0;

  // Tone accumulator width sets the tone scale
  localparam int TONE_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       start;
    logic [7:0] data;
  } tsop_byte_type;

  typedef enum logic {PH_LOW, PH_HIGH} tsop_phase_type;

endpackage : tsop_pkg

// ===== hw/tsop_port.sv
// Design decisions made here: the register offsets and strobed register access.
module tsop_port (
  input  wire logic                 clk,                   // 25 MHz clock
  input  wire logic                 reset_n,               // Async reset
  input  wire logic [7:0]           addr,                  // Register byte address
  input  wire logic [7:0]           wdata,                 // Write data
  input  wire logic                 wr,                    // Write strobe
  input  wire logic                 rd,                    // Read strobe
  output logic      [7:0]           rdata,                 // Read data, cycle after rd
  input  wire tsop_pkg::tsop_byte_type in_byte,            // Decoded byte and start flag
  input  wire logic                 in_valid,              // Byte offered
  output logic                      in_ready,              // Byte slot free
  input  wire logic                 block_uncorrectable,   // Pulse per failed block
  input  wire logic                 signal_lock,           // Level, signal present
  input  wire logic [15:0]          ber_rate,              // Measured error rate
  output logic      [7:0]           transport_data_out,    // Data bus
  output logic                      transport_data_oe,     // Data bus enable
  output logic                      packet_start_out,      // First byte strobe
  output logic                      packet_start_oe,       // Start enable
  output logic                      byte_valid_out,        // Byte valid strobe
  output logic                      byte_valid_oe,         // Valid enable
  output logic                      byte_clock_out,        // Byte rate clock
  output logic                      byte_clock_oe,         // Clock enable
  output logic                      block_error_n,         // Error pin
  output logic                      block_error_oe,        // Error enable
  input  wire logic                 irq_pin_in,            // Level seen on irq pin
  output logic                      irq_pin_out,           // Open drain, always low
  output logic                      irq_pin_oe,            // High while pulling low
  output logic                      transport_input_clock, // Clock taken from irq pin
  output logic                      status_out,            // Status pin
  output logic                      irq                    // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0]                ctrl_q,    ctrl_d;
  logic [7:0]                mon_q,     mon_d;
  logic [7:0]                div_q,     div_d;
  logic [tsop_pkg::IRQ_W-1:0] stat_q,   stat_d;
  logic [tsop_pkg::IRQ_W-1:0] en_q,     en_d;
  logic                      ack_q,     ack_d;
  logic [7:0]                rdata_d;
  logic [tsop_pkg::IRQ_W-1:0] ev;
  logic [tsop_pkg::IRQ_W-1:0] clr;
  logic                      rd_stat;

  // Byte path
  tsop_pkg::tsop_phase_type  ph_q,      ph_d;
  logic [7:0]                cnt_q,     cnt_d;
  tsop_pkg::tsop_byte_type   hold_q,    hold_d;
  logic                      full_q,    full_d;
  logic                      ready_q,   ready_d;
  tsop_pkg::tsop_byte_type   out_q,     out_d;
  logic                      valid_q,   valid_d;
  logic                      tick;
  logic                      unload;
  logic                      accept;

  // Error and status
  logic                      lock_q;
  logic                      blk_q,     blk_d;
  logic [tsop_pkg::TONE_W-1:0] acc_q,   acc_d;
  logic                      err;
  logic                      drive_q,   drive_d;
  logic                      errn_q,    errn_d;
  logic                      stat_pin_q, stat_pin_d;
  logic                      irq_oe_q,  irq_oe_d;
  logic                      ext_clk_q, ext_clk_d;
  logic                      irq_q,     irq_d;
  logic [1:0]                sel;

  assign sel     = ctrl_q[tsop_pkg::CTRL_SEL_HI:tsop_pkg::CTRL_SEL_LO];
  assign rd_stat = rd && (addr == tsop_pkg::ADDR_IRQ_STAT);
  assign clr     = (wr && addr == tsop_pkg::ADDR_IRQ_CLR) ? wdata[tsop_pkg::IRQ_W-1:0] : '0;

  always_comb begin
    ctrl_d  = ctrl_q;
    mon_d   = mon_q;
    div_d   = div_q;
    en_d    = en_q;
    rdata_d = 8'h00;
    if (wr) begin
      case (addr)
        tsop_pkg::ADDR_CTRL:    ctrl_d = wdata;
        tsop_pkg::ADDR_MONITOR: mon_d  = wdata;
        tsop_pkg::ADDR_DIVIDER: div_d  = wdata;
        tsop_pkg::ADDR_IRQ_EN:  en_d   = wdata[tsop_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        tsop_pkg::ADDR_CTRL:     rdata_d = ctrl_q;
        tsop_pkg::ADDR_MONITOR:  rdata_d = mon_q;
        tsop_pkg::ADDR_DIVIDER:  rdata_d = div_q;
        tsop_pkg::ADDR_IRQ_STAT: rdata_d = {5'h00, stat_q};
        tsop_pkg::ADDR_IRQ_EN:   rdata_d = {5'h00, en_q};
        tsop_pkg::ADDR_LIVE:     rdata_d = {5'h00, blk_q, full_q, lock_q};
        default:                 rdata_d = 8'h00;
      endcase
    end
    // Set wins over a clear in the same cycle
    stat_d = (stat_q & ~clr) | ev;
    // A fresh enabled event re-arms the pin even during a read
    if (|(ev & en_q)) begin
      ack_d = 1'b0;
    end else if (rd_stat) begin
      ack_d = 1'b1;
    end else begin
      ack_d = ack_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= tsop_pkg::CTRL_RST;
      mon_q  <= tsop_pkg::MONITOR_RST;
      div_q  <= tsop_pkg::DIVIDER_RST;
      en_q   <= tsop_pkg::IRQ_EN_RST;
      stat_q <= '0;
      ack_q  <= 1'b0;
      rdata  <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      mon_q  <= mon_d;
      div_q  <= div_d;
      en_q   <= en_d;
      stat_q <= stat_d;
      ack_q  <= ack_d;
      rdata  <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte clock divider and output stage
  // Lowering the divider mid-count must not stall the clock for a full wrap
  assign tick   = (cnt_q >= div_q);
  assign unload = tick && (ph_q == tsop_pkg::PH_HIGH);
  assign accept = in_valid && ready_q;

  always_comb begin
    cnt_d   = tick ? 8'h00 : 8'(cnt_q + 8'h01);
    ph_d    = ph_q;
    out_d   = out_q;
    valid_d = valid_q;
    hold_d  = hold_q;
    full_d  = full_q;
    if (tick) begin
      ph_d = (ph_q == tsop_pkg::PH_HIGH) ? tsop_pkg::PH_LOW : tsop_pkg::PH_HIGH;
    end
    // One byte per clock period, loaded at the falling edge
    if (unload) begin
      valid_d = full_q;
      if (full_q) begin
        out_d  = hold_q;
        full_d = 1'b0;
      end else begin
        out_d.start = 1'b0;
      end
    end
    if (accept) begin
      hold_d = in_byte;
      full_d = 1'b1;
    end
    ready_d = ~full_d;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q   <= 8'h00;
      ph_q    <= tsop_pkg::PH_LOW;
      out_q   <= '0;
      valid_q <= 1'b0;
      hold_q  <= '0;
      full_q  <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      ph_q    <= ph_d;
      out_q   <= out_d;
      valid_q <= valid_d;
      hold_q  <= hold_d;
      full_q  <= full_d;
      ready_q <= ready_d;
    end
  end

  assign transport_data_out = out_q.data;
  assign packet_start_out   = out_q.start;
  assign byte_valid_out     = valid_q;
  assign byte_clock_out     = (ph_q == tsop_pkg::PH_HIGH);
  assign in_ready           = ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // Events, error pin, status pin, interrupt pin
  // Block error is held until the next packet start leaves the port
  assign ev[tsop_pkg::IRQ_PKT] = unload && full_q && hold_q.start;
  assign ev[tsop_pkg::IRQ_BLK] = block_uncorrectable;
  assign ev[tsop_pkg::IRQ_LOS] = lock_q && !signal_lock;
  assign err = mon_q[tsop_pkg::MON_ERR_SRC] ? !lock_q : blk_q;

  always_comb begin
    blk_d = blk_q;
    if (ev[tsop_pkg::IRQ_PKT]) begin
      blk_d = 1'b0;
    end
    if (block_uncorrectable) begin
      blk_d = 1'b1;
    end
    acc_d   = acc_q + tsop_pkg::TONE_W'(ber_rate);
    drive_d = !ctrl_q[tsop_pkg::CTRL_TRISTATE];
    errn_d  = ctrl_q[tsop_pkg::CTRL_ERR_INV] ? err : !err;
    case (sel)
      tsop_pkg::SEL_LOCK:  stat_pin_d = lock_q;
      tsop_pkg::SEL_TONE:  stat_pin_d = acc_q[tsop_pkg::TONE_W-1];
      tsop_pkg::SEL_ERROR: stat_pin_d = err;
      tsop_pkg::SEL_START: stat_pin_d = out_q.start;
      default:             stat_pin_d = 1'b0;
    endcase
    // In clock-input mode the pin is never driven
    irq_oe_d = !ctrl_q[tsop_pkg::CTRL_IRQ_CLK] && (|(stat_q & en_q)) && !ack_q;
    ext_clk_d = ctrl_q[tsop_pkg::CTRL_IRQ_CLK] && irq_pin_in;
    irq_d    = |(stat_q & en_q);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_q     <= 1'b0;
      blk_q      <= 1'b0;
      acc_q      <= '0;
      drive_q    <= 1'b0;
      errn_q     <= 1'b1;
      stat_pin_q <= 1'b0;
      irq_oe_q   <= 1'b0;
      ext_clk_q  <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      lock_q     <= signal_lock;
      blk_q      <= blk_d;
      acc_q      <= acc_d;
      drive_q    <= drive_d;
      errn_q     <= errn_d;
      stat_pin_q <= stat_pin_d;
      irq_oe_q   <= irq_oe_d;
      ext_clk_q  <= ext_clk_d;
      irq_q      <= irq_d;
    end
  end

  assign transport_data_oe     = drive_q;
  assign packet_start_oe       = drive_q;
  assign byte_valid_oe         = drive_q;
  assign byte_clock_oe         = drive_q;
  assign block_error_oe        = drive_q;
  assign block_error_n         = errn_q;
  assign status_out            = stat_pin_q;
  assign irq_pin_out           = 1'b0;
  assign irq_pin_oe            = irq_oe_q;
  assign transport_input_clock = ext_clk_q;
  assign irq                   = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_start_with_valid: assert property (@(posedge clk) disable iff (!reset_n)
    packet_start_out |-> byte_valid_out)
    else $error("start without valid byte");

  a_start_from_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (unload && full_q) |=> (packet_start_out == $past(hold_q.start)))
    else $error("start flag not from loaded byte");

  a_valid_byte: assert property (@(posedge clk) disable iff (!reset_n)
    (unload && full_q) |=> byte_valid_out && (transport_data_out == $past(hold_q.data)))
    else $error("valid byte not presented");

  a_valid_empty: assert property (@(posedge clk) disable iff (!reset_n)
    (unload && !full_q) |=> !byte_valid_out)
    else $error("valid high with no byte");

  a_bus_tristate: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_q[tsop_pkg::CTRL_TRISTATE] |=> !transport_data_oe)
    else $error("data bus driven while tristated");

  a_clock_tick: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(byte_clock_out) |-> $past(tick))
    else $error("byte clock moved off divider tick");

  a_error_pin: assert property (@(posedge clk) disable iff (!reset_n)
    !ctrl_q[tsop_pkg::CTRL_ERR_INV] |=> (block_error_n == !$past(err)))
    else $error("error pin wrong source or level");

  a_error_invert: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_q[tsop_pkg::CTRL_ERR_INV] |=> (block_error_n == $past(err)))
    else $error("error pin not inverted");

  a_irq_release: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_stat && !(|(ev & en_q))) ##1 !(|(ev & en_q)) |=> !irq_pin_oe)
    else $error("interrupt pin held after status read");

  a_irq_as_clock: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_q[tsop_pkg::CTRL_IRQ_CLK] |=> !irq_pin_oe && (transport_input_clock == $past(irq_pin_in)))
    else $error("irq pin driven in clock mode");

  a_status_tone: assert property (@(posedge clk) disable iff (!reset_n)
    (sel == tsop_pkg::SEL_TONE) |=> (status_out == $past(acc_q[tsop_pkg::TONE_W-1])))
    else $error("status tone wrong");

  a_data_stable: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_clock_out && $past(byte_clock_out)) |-> $stable(transport_data_out)
      && $stable(byte_valid_out) && $stable(packet_start_out))
    else $error("outputs changed while byte clock high");

endmodule : tsop_port

// ===== dv/tsop_sink.sv
module tsop_sink (
  input wire logic       byte_clock_out,     // Byte rate clock
  input wire logic [7:0] transport_data_out, // Data bus
  input wire logic       packet_start_out,   // First byte strobe
  input wire logic       byte_valid_out      // Byte valid strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [8:0] got[$];

  // Sample on the rising edge, half a period away from the launch edge
  always @(posedge byte_clock_out) begin
    if (byte_valid_out === 1'b1) begin
      got.push_back({packet_start_out, transport_data_out});
    end
  end
endmodule : tsop_sink

// ===== dv/tb_transport_stream_output_port.sv
module tb_transport_stream_output_port;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic                    in_valid = 1'b0, blk = 1'b0, lock = 1'b1, ext_lvl = 1'b1;
  logic [7:0]              addr = 8'h00, wdata = 8'h00, rdata, dout;
  logic [15:0]             ber = 16'h0000;
  tsop_pkg::tsop_byte_type in_byte = '0;
  logic                    in_ready, data_oe, st, st_oe, vld, vld_oe, bclk, bclk_oe;
  logic                    err_n, err_oe, irq_out, irq_oe, mclk, status, irq;
  int                      num_errors = 0, num_checks = 0;
  // Open-drain pin idles high through its pull-up
  wire                     irq_wire = irq_oe ? irq_out : ext_lvl;
  logic [7:0]              row_addr[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [7:0]              row_exp[8]  = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0]              pk[4]       = '{8'h47, 8'hA1, 8'hB2, 8'hC3};

  always #20 clk = ~clk;

  tsop_port tsop_port_inst (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready),
    .block_uncorrectable(blk), .signal_lock(lock), .ber_rate(ber), .transport_data_out(dout),
    .transport_data_oe(data_oe), .packet_start_out(st), .packet_start_oe(st_oe),
    .byte_valid_out(vld), .byte_valid_oe(vld_oe), .byte_clock_out(bclk), .byte_clock_oe(bclk_oe),
    .block_error_n(err_n), .block_error_oe(err_oe), .irq_pin_in(irq_wire), .irq_pin_out(irq_out),
    .irq_pin_oe(irq_oe), .transport_input_clock(mclk), .status_out(status), .irq(irq));

  tsop_sink tsop_sink_inst (.byte_clock_out(bclk), .transport_data_out(dout),
    .packet_start_out(st), .byte_valid_out(vld));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic hang();
    num_errors++;
    $display("[ERR] wait_bound expected done seen timeout");
    close_out();
  endtask : hang

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask : rd_reg

  task automatic pulse_blk();
    @(posedge clk);
    blk <= 1'b1;
    @(posedge clk);
    blk <= 1'b0;
  endtask : pulse_blk

  // Offer one byte and hold it until the slot takes it
  task automatic put(input logic s, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    in_valid <= 1'b1;
    in_byte <= tsop_pkg::tsop_byte_type'{s, d};
    #1;
    while (in_ready !== 1'b1) begin
      if (++n > 200) hang();
      w(1);
    end
    @(posedge clk);
    in_valid <= 1'b0;
  endtask : put

  // Clock cycles up to the next rising byte clock edge
  task automatic rise(output int c);
    logic p;
    c = 0;
    p = bclk;
    do begin
      w(1);
      if (++c > 100) hang();
      if (bclk === 1'b1 && p === 1'b0) break;
      p = bclk;
    end while (1);
  endtask : rise

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int c;
    logic p;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    w(2);
    chk("data_oe", 8'h01, data_oe);
    chk("block_error_n", 8'h01, err_n);
    chk("irq_pin_oe", 8'h00, irq_oe);
    for (int i = 0; i < 8; i++) rd_reg(row_addr[i], row_exp[i]);
    wr_reg(8'h1C, 8'hFF);
    rd_reg(8'h1C, 8'h00);
    $display("test reset done");

    wr_reg(tsop_pkg::ADDR_IRQ_EN, 8'h01);
    for (int i = 0; i < 4; i++) put(i == 0, pk[i]);
    n = 0;
    while (tsop_sink_inst.got.size() < 4) begin
      if (++n > 400) hang();
      w(1);
    end
    w(10);
    for (int i = 0; i < 4; i++) begin
      chk("rx_data", pk[i], tsop_sink_inst.got[i][7:0]);
      chk("rx_start", {7'h00, i == 0}, {7'h00, tsop_sink_inst.got[i][8]});
    end
    chk("byte_valid_idle", 8'h00, vld);
    chk("irq", 8'h01, irq);
    chk("irq_wire", 8'h00, irq_wire);
    rd_reg(tsop_pkg::ADDR_IRQ_STAT, 8'h01);
    w(2);
    chk("irq_pin_released", 8'h00, irq_oe);
    wr_reg(tsop_pkg::ADDR_IRQ_CLR, 8'h01);
    w(3);
    chk("irq_cleared", 8'h00, irq);
    $display("test stream done");

    for (int d = 1; d < 5; d += 2) begin
      wr_reg(tsop_pkg::ADDR_DIVIDER, d[7:0]);
      rise(c);
      rise(c);
      chk("byte_period", 8'(2 * (d + 1)), 8'(c));
    end
    wr_reg(tsop_pkg::ADDR_DIVIDER, 8'h01);
    $display("test period done");

    wr_reg(tsop_pkg::ADDR_IRQ_EN, 8'h00);
    pulse_blk();
    w(3);
    chk("block_error_n", 8'h00, err_n);
    rd_reg(tsop_pkg::ADDR_LIVE, 8'h05);
    w(1);
    chk("rdata_idle", 8'h00, rdata);
    rd_reg(tsop_pkg::ADDR_IRQ_STAT, 8'h02);
    chk("irq_masked", 8'h00, irq);
    wr_reg(tsop_pkg::ADDR_CTRL, 8'h02);
    w(3);
    chk("error_inverted", 8'h01, err_n);
    wr_reg(tsop_pkg::ADDR_CTRL, 8'h00);
    wr_reg(tsop_pkg::ADDR_MONITOR, 8'h80);
    w(3);
    chk("lock_error", 8'h01, err_n);
    @(posedge clk);
    lock <= 1'b0;
    w(4);
    chk("lost_lock_error", 8'h00, err_n);
    @(posedge clk);
    lock <= 1'b1;
    wr_reg(tsop_pkg::ADDR_MONITOR, 8'h00);
    wr_reg(tsop_pkg::ADDR_CTRL, 8'h01);
    w(3);
    chk("tristate_data", 8'h00, data_oe);
    chk("tristate_error", 8'h00, err_oe);
    chk("tristate_start", 8'h00, st_oe);
    chk("tristate_valid", 8'h00, vld_oe);
    chk("tristate_clock", 8'h00, bclk_oe);
    $display("test error done");

    wr_reg(tsop_pkg::ADDR_IRQ_CLR, 8'h07);
    wr_reg(tsop_pkg::ADDR_CTRL, 8'h04);
    wr_reg(tsop_pkg::ADDR_IRQ_EN, 8'h02);
    pulse_blk();
    w(3);
    chk("irq_clock_mode", 8'h01, irq);
    chk("irq_pin_clock_mode", 8'h00, irq_oe);
    @(posedge clk);
    ext_lvl <= 1'b0;
    w(3);
    chk("input_clock_low", 8'h00, mclk);
    @(posedge clk);
    ext_lvl <= 1'b1;
    w(3);
    chk("input_clock_high", 8'h01, mclk);
    wr_reg(tsop_pkg::ADDR_CTRL, 8'h00);
    w(3);
    chk("irq_pin_back", 8'h01, irq_oe);
    wr_reg(tsop_pkg::ADDR_IRQ_CLR, 8'h07);
    $display("test clock mode done");

    w(3);
    chk("status_lock", 8'h01, status);
    @(posedge clk);
    ber <= 16'h8000;
    wr_reg(tsop_pkg::ADDR_CTRL, 8'h10);
    w(4);
    c = 0;
    p = status;
    // A half step of the tone accumulator flips its top bit every 16 cycles
    repeat (64) begin
      w(1);
      if (status !== p) c++;
      p = status;
    end
    chk("tone_toggles", 8'h04, 8'(c));
    // Block error flag is still pending here, and no start byte is on the bus
    wr_reg(tsop_pkg::ADDR_CTRL, 8'h20);
    w(3);
    chk("status_error", 8'h01, status);
    wr_reg(tsop_pkg::ADDR_CTRL, 8'h30);
    w(3);
    chk("status_start", 8'h00, status);
    $display("test status done");

    @(posedge clk);
    reset_n <= 1'b0;
    w(2);
    chk("rst_rdata", 8'h00, rdata);
    chk("rst_in_ready", 8'h00, in_ready);
    chk("rst_data_oe", 8'h00, data_oe);
    chk("rst_error", 8'h01, err_n);
    chk("rst_irq", 8'h00, irq);
    @(posedge clk);
    reset_n <= 1'b1;
    w(3);
    chk("in_ready_after_reset", 8'h01, in_ready);
    chk("status_after_reset", 8'h01, status);
    rd_reg(tsop_pkg::ADDR_CTRL, 8'h00);
    rd_reg(tsop_pkg::ADDR_IRQ_STAT, 8'h00);
    $display("test reset again done");
    close_out();
  end
endmodule : tb_transport_stream_output_port
